// ---- verilog/sirs_i2c_target.sv ----
// I2C target of the sensor register port: pointer, burst reads, writes, watchdog.
// Assumes pins are oversampled by clk and the register file answers read requests
// through the rdData/rdValid stream within a few cycles.
`timescale 1ns/100ps

module sirs_i2c_target import sirs_pkg::*; #(
	parameter logic [WDT_CNT_W-1:0] WDT_SHORT_CYCLES = WDT_CNT_W'(WDT_SHORT_CYC),
	parameter logic [WDT_CNT_W-1:0] WDT_LONG_CYCLES = WDT_CNT_W'(WDT_LONG_CYC)
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clkEn,
	input wire logic serialClockPin,
	input wire logic serialDataIn,
	output logic serialDataOut,
	output logic serialDataOe,
	input wire logic addressSelectPin,
	input wire logic wdtEnable,
	input wire logic wdtLongSel,
	output logic rdReq,
	output logic [BYTE_W-1:0] rdAddr,
	input wire logic [BYTE_W-1:0] rdData,
	input wire logic rdValid,
	output logic rdReady,
	output logic wrStrobe,
	output logic [BYTE_W-1:0] wrAddr,
	output logic [BYTE_W-1:0] wrData,
	output logic busy,
	output logic wdtTrip
);
	// ****************************************
	// Reset release and pin sampling
	// ****************************************
	logic [1:0] rstPipe_reg;
	logic rstSync_n;
	logic [2:0] sclSync_reg;
	logic [2:0] sdaSync_reg;
	logic [2:0] selSync_reg;
	logic sclLevel_reg;
	logic sdaLevel_reg;
	logic selLevel_reg;
	logic sclNew;
	logic sdaNew;
	logic sclRise;
	logic sclFall;
	logic startEv;
	logic stopEv;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rstPipe_reg <= 2'h0;
		end else begin
			rstPipe_reg <= {rstPipe_reg[0], 1'b1};
		end
	end
	assign rstSync_n = rstPipe_reg[1];

	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			sclSync_reg <= 3'h7;
			sdaSync_reg <= 3'h7;
			selSync_reg <= 3'h0;
			sclLevel_reg <= 1'b1;
			sdaLevel_reg <= 1'b1;
			selLevel_reg <= 1'b0;
		end else if (clkEn) begin
			sclSync_reg <= {sclSync_reg[1:0], serialClockPin};
			sdaSync_reg <= {sdaSync_reg[1:0], serialDataIn};
			selSync_reg <= {selSync_reg[1:0], addressSelectPin};
			sclLevel_reg <= sclNew;
			sdaLevel_reg <= sdaNew;
			if (selSync_reg[1] == selSync_reg[2]) begin
				selLevel_reg <= selSync_reg[2];
			end
		end
	end

	// A level changes only once the second and third stages agree.
	assign sclNew = (sclSync_reg[1] == sclSync_reg[2]) ? sclSync_reg[2] : sclLevel_reg;
	assign sdaNew = (sdaSync_reg[1] == sdaSync_reg[2]) ? sdaSync_reg[2] : sdaLevel_reg;
	assign sclRise = sclNew && !sclLevel_reg;
	assign sclFall = !sclNew && sclLevel_reg;
	assign startEv = sclLevel_reg && sclNew && sdaLevel_reg && !sdaNew;
	assign stopEv = sclLevel_reg && sclNew && !sdaLevel_reg && sdaNew;

	// ****************************************
	// Read byte buffer
	// ****************************************
	sirs_stream_if #(.W(BYTE_W)) userIf ();
	sirs_stream_if #(.W(BYTE_W)) engIf ();
	logic flushBuf;

	assign userIf.data = rdData;
	assign userIf.valid = rdValid;
	assign rdReady = userIf.ready;

	sirs_skid_buffer #(.WIDTH(BYTE_W), .DEPTH(BUF_DEPTH)) u_buf (
		.clk(clk),
		.rstN(rstSync_n),
		.clkEn(clkEn),
		.flush(flushBuf),
		.inS(userIf),
		.outS(engIf)
	);

	// ****************************************
	// Sequencer
	// ****************************************
	sirs_state_t state_reg;
	logic [3:0] bitCnt_reg;
	logic [7:0] rxShift_reg;
	logic [7:0] txShift_reg;
	logic sdaOe_reg;
	logic isRead_reg;
	logic nack_reg;
	logic [7:0] regPtr_reg;
	logic [7:0] readStart_reg;
	logic [6:0] selAddr;
	logic addrDone;
	logic addrMatch;
	logic readMatch;
	logic regDone;
	logic wdataDone;
	logic loadByte;
	logic [7:0] nextByte;
	logic wdtFire;

	function automatic logic [6:0] pickAddr(input logic sel);
		pickAddr = sel ? TARGET_ADDR_HIGH : TARGET_ADDR_LOW;
	endfunction

	assign selAddr = pickAddr(selLevel_reg);
	assign addrMatch = (rxShift_reg[7:1] == selAddr);
	assign addrDone = (state_reg == ST_ADDR) && sclFall && (bitCnt_reg == BIT_FULL);
	assign readMatch = addrDone && addrMatch && (rxShift_reg[0] == DIR_READ);
	assign regDone = (state_reg == ST_REG) && sclFall && (bitCnt_reg == BIT_FULL);
	assign wdataDone = (state_reg == ST_WDATA) && sclFall && (bitCnt_reg == BIT_FULL);
	assign loadByte = sclFall && (((state_reg == ST_ADDR_ACK) && isRead_reg) ||
		((state_reg == ST_RACK) && !nack_reg));
	assign nextByte = engIf.valid ? engIf.data : EMPTY_BYTE;
	assign engIf.ready = loadByte;
	assign flushBuf = startEv || stopEv || wdtFire;

	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			state_reg <= ST_IDLE;
			bitCnt_reg <= BIT_ZERO;
			rxShift_reg <= 8'h00;
			txShift_reg <= 8'h00;
			sdaOe_reg <= 1'b0;
			isRead_reg <= 1'b0;
			nack_reg <= 1'b0;
		end else if (clkEn) begin
			if (wdtFire) begin
				state_reg <= ST_IDLE;
				sdaOe_reg <= 1'b0;
			end else if (startEv) begin
				state_reg <= ST_ADDR;
				bitCnt_reg <= BIT_ZERO;
				sdaOe_reg <= 1'b0;
			end else if (stopEv) begin
				state_reg <= ST_IDLE;
				sdaOe_reg <= 1'b0;
			end else begin
				case (state_reg)
					ST_ADDR, ST_REG, ST_WDATA: begin
						if (sclRise) begin
							rxShift_reg <= {rxShift_reg[6:0], sdaNew};
							bitCnt_reg <= bitCnt_reg + BIT_STEP;
						end
						if (addrDone) begin
							if (addrMatch) begin
								state_reg <= ST_ADDR_ACK;
								sdaOe_reg <= 1'b1;
								isRead_reg <= rxShift_reg[0];
							end else begin
								state_reg <= ST_IGNORE;
							end
						end else if (regDone || wdataDone) begin
							state_reg <= ST_WACK;
							sdaOe_reg <= 1'b1;
						end
					end
					ST_ADDR_ACK: begin
						if (sclFall) begin
							bitCnt_reg <= BIT_ZERO;
							if (isRead_reg) begin
								state_reg <= ST_RDATA;
								txShift_reg <= nextByte;
								sdaOe_reg <= !nextByte[7];
							end else begin
								state_reg <= ST_REG;
								sdaOe_reg <= 1'b0;
							end
						end
					end
					ST_WACK: begin
						if (sclFall) begin
							state_reg <= ST_WDATA;
							bitCnt_reg <= BIT_ZERO;
							sdaOe_reg <= 1'b0;
						end
					end
					ST_RDATA: begin
						if (sclRise) begin
							bitCnt_reg <= bitCnt_reg + BIT_STEP;
						end
						if (sclFall) begin
							if (bitCnt_reg == BIT_FULL) begin
								state_reg <= ST_RACK;
								sdaOe_reg <= 1'b0;
							end else begin
								txShift_reg <= {txShift_reg[6:0], 1'b1};
								sdaOe_reg <= !txShift_reg[6];
							end
						end
					end
					ST_RACK: begin
						if (sclRise) begin
							nack_reg <= sdaNew;
						end
						if (sclFall) begin
							bitCnt_reg <= BIT_ZERO;
							if (nack_reg) begin
								state_reg <= ST_IGNORE;
								sdaOe_reg <= 1'b0;
							end else begin
								state_reg <= ST_RDATA;
								txShift_reg <= nextByte;
								sdaOe_reg <= !nextByte[7];
							end
						end
					end
					default: begin
						sdaOe_reg <= 1'b0;
					end
				endcase
			end
		end
	end

	// ****************************************
	// Register pointer and register file strobes
	// ****************************************
	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			readStart_reg <= READ_START_RESET;
			regPtr_reg <= READ_START_RESET;
		end else if (clkEn) begin
			if (regDone) begin
				readStart_reg <= rxShift_reg;
				regPtr_reg <= rxShift_reg;
			end else if (readMatch) begin
				regPtr_reg <= readStart_reg;
			end else if (loadByte || wdataDone) begin
				regPtr_reg <= regPtr_reg + PTR_STEP;
			end
		end
	end

	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			rdReq <= 1'b0;
			rdAddr <= 8'h00;
			wrStrobe <= 1'b0;
			wrAddr <= 8'h00;
			wrData <= 8'h00;
		end else if (clkEn) begin
			rdReq <= readMatch || loadByte;
			if (readMatch) begin
				rdAddr <= readStart_reg;
			end else if (loadByte) begin
				rdAddr <= regPtr_reg + PTR_STEP;
			end
			wrStrobe <= wdataDone;
			if (wdataDone) begin
				wrAddr <= regPtr_reg;
				wrData <= rxShift_reg;
			end
		end
	end

	// ****************************************
	// Lock-up watchdog and status
	// ****************************************
	logic [WDT_CNT_W-1:0] wdtCount_reg;
	logic [WDT_CNT_W-1:0] wdtLimit;

	assign wdtLimit = wdtLongSel ? WDT_LONG_CYCLES : WDT_SHORT_CYCLES;
	// fire while target holds data low
	assign wdtFire = wdtEnable && sdaOe_reg &&
		(wdtCount_reg == WDT_CNT_W'(wdtLimit - WDT_CNT_W'(1)));

	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			wdtCount_reg <= '0;
			wdtTrip <= 1'b0;
			busy <= 1'b0;
			serialDataOut <= 1'b0;
			serialDataOe <= 1'b0;
		end else if (clkEn) begin
			// A moving clock means the bus is alive, so only a frozen hold counts.
			if (!wdtEnable || !sdaOe_reg || wdtFire || sclRise || sclFall) begin
				wdtCount_reg <= '0;
			end else begin
				wdtCount_reg <= wdtCount_reg + WDT_CNT_W'(1);
			end
			wdtTrip <= wdtFire;
			if (wdtFire || stopEv) begin
				busy <= 1'b0;
			end else if (startEv) begin
				busy <= 1'b1;
			end
			serialDataOut <= 1'b0;
			serialDataOe <= sdaOe_reg && !wdtFire;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cbMain @(posedge clk);
	endclocking
	default disable iff (!rstSync_n || !clkEn);

	sequence seqAddrDone;
		addrDone && !wdtFire;
	endsequence
	sequence seqAckDriven;
		state_reg == ST_ADDR_ACK && sdaOe_reg;
	endsequence

	chk_addr_ack_match: assert property (
		seqAddrDone ##0 addrMatch |=> seqAckDriven)
		else $error("matching address not acknowledged");
	chk_addr_foreign: assert property (
		seqAddrDone ##0 !addrMatch |=> state_reg == ST_IGNORE && !sdaOe_reg)
		else $error("foreign address acknowledged");
	chk_ignore_silent: assert property (
		state_reg == ST_IGNORE |-> !sdaOe_reg)
		else $error("data line driven while ignoring");
	chk_nack_release: assert property (
		state_reg == ST_RACK && sclFall && nack_reg && !wdtFire && !startEv
		|=> state_reg == ST_IGNORE && !sdaOe_reg ##1 !serialDataOe)
		else $error("data line not released after not-acknowledge");
	chk_ptr_step: assert property (
		loadByte |=> regPtr_reg == 8'($past(regPtr_reg) + PTR_STEP) && rdReq)
		else $error("pointer did not advance after sent byte");
	chk_read_start: assert property (
		readMatch |=> regPtr_reg == $past(readStart_reg) && rdAddr == $past(readStart_reg))
		else $error("read did not restart at written address");
	chk_reg_latch: assert property (
		regDone && !wdtFire |=> readStart_reg == $past(rxShift_reg) && state_reg == ST_WACK)
		else $error("register address byte not taken");
	chk_tx_bit: assert property (
		state_reg == ST_RDATA && $stable(state_reg) |-> sdaOe_reg == !txShift_reg[7])
		else $error("data bit driven wrong");
	chk_wdt_reset: assert property (
		wdtTrip |-> state_reg == ST_IDLE && !sdaOe_reg && !busy)
		else $error("watchdog did not return target to idle");
	chk_wdt_off: assert property (
		!wdtEnable |=> wdtCount_reg == '0 && !wdtTrip)
		else $error("watchdog counts while disabled");

endmodule

// ---- verilog/sirs_pkg.sv ----
// Shared constants and types of the sensor I2C register target.
// Assumes a 40 MHz system clock and a 7-bit addressed I2C bus.
package sirs_pkg;

	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLK_FREQ_MHZ = 40;
	localparam int WDT_SHORT_US = 1250;
	localparam int WDT_LONG_US = 40000;
	localparam int WDT_SHORT_CYC = WDT_SHORT_US * CLK_FREQ_MHZ;
	localparam int WDT_LONG_CYC = WDT_LONG_US * CLK_FREQ_MHZ;
	localparam int WDT_CNT_W = 24;
	localparam int IDLE_NORMAL_NS = 2000;
	localparam int IDLE_SUSPEND_US = 1000;

	// ****************************************
	// Bus layout
	// ****************************************
	localparam int BYTE_W = 8;
	localparam int BUF_DEPTH = 2;
	localparam logic [6:0] TARGET_ADDR_LOW = 7'h18;
	localparam logic [6:0] TARGET_ADDR_HIGH = 7'h19;
	localparam logic DIR_READ = 1'b1;
	localparam logic [7:0] READ_START_RESET = 8'h00;
	localparam logic [7:0] PTR_STEP = 8'h01;
	localparam logic [7:0] EMPTY_BYTE = 8'hff;
	localparam logic [3:0] BIT_FULL = 4'h8;
	localparam logic [3:0] BIT_STEP = 4'h1;
	localparam logic [3:0] BIT_ZERO = 4'h0;

	// ****************************************
	// Target sequencer states
	// ****************************************
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_ADDR_ACK = 4'h2,
		ST_REG = 4'h3,
		ST_WDATA = 4'h4,
		ST_WACK = 4'h5,
		ST_RDATA = 4'h6,
		ST_RACK = 4'h7,
		ST_IGNORE = 4'h8
	} sirs_state_t;

endpackage

// ---- verilog/sirs_stream_if.sv ----
// Valid/ready byte stream between the target's own modules.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface sirs_stream_if #(parameter int W = 8) ();
	logic [W-1:0] data;
	logic valid;
	logic ready;
	modport src(output data, output valid, input ready);
	modport snk(input data, input valid, output ready);
endinterface

// ---- verilog/sirs_skid_buffer.sv ----
// Small FIFO that holds read bytes between the register file and the target.
// Assumes a synchronous reset copy and a shared clock enable.
`timescale 1ns/100ps
module sirs_skid_buffer import sirs_pkg::*; #(
	parameter int WIDTH = BYTE_W,
	parameter int DEPTH = BUF_DEPTH
) (
	input wire logic clk,
	input wire logic rstN,
	input wire logic clkEn,
	input wire logic flush,
	sirs_stream_if.snk inS,
	sirs_stream_if.src outS
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wrPtr_reg;
	logic [PW-1:0] rdPtr_reg;
	logic [CW-1:0] count_reg;
	logic [CW-1:0] count_next;
	logic notFull_reg;
	logic notEmpty_reg;
	logic push;
	logic pop;

	function automatic logic [PW-1:0] stepPtr(input logic [PW-1:0] p);
		if (int'(p) == DEPTH - 1) begin
			stepPtr = '0;
		end else begin
			stepPtr = PW'(int'(p) + 1);
		end
	endfunction

	assign push = inS.valid && notFull_reg;
	assign pop = outS.ready && notEmpty_reg;
	assign inS.ready = notFull_reg;
	assign outS.valid = notEmpty_reg;
	assign outS.data = mem[rdPtr_reg];

	always_comb begin
		if (flush) begin
			count_next = '0;
		end else begin
			count_next = CW'(count_reg + CW'(push) - CW'(pop));
		end
	end

	always_ff @(posedge clk) begin
		if (clkEn && push) begin
			mem[wrPtr_reg] <= inS.data;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
			notFull_reg <= 1'b1;
			notEmpty_reg <= 1'b0;
		end else if (clkEn) begin
			if (flush) begin
				wrPtr_reg <= '0;
				rdPtr_reg <= '0;
			end else begin
				if (push) begin
					wrPtr_reg <= stepPtr(wrPtr_reg);
				end
				if (pop) begin
					rdPtr_reg <= stepPtr(rdPtr_reg);
				end
			end
			count_reg <= count_next;
			notFull_reg <= (int'(count_next) != DEPTH);
			notEmpty_reg <= (count_next != '0);
		end
	end

	chk_buf_bound: assert property (@(posedge clk) disable iff (!rstN)
		int'(count_reg) <= DEPTH && notFull_reg == (int'(count_reg) != DEPTH))
		else $error("buffer count out of range or full flag wrong");

endmodule

// ---- tb/sirs_ctrl_model.sv ----
// Behavioural I2C bus controller that drives the target's clock and data pins.
// Assumes an open-drain data wire resolved by the bench and a free-running link clock.
`timescale 1ns/100ps
module sirs_ctrl_model import sirs_pkg::*; #(
	parameter int HALF_CYC = 12
) (
	input wire logic lclk,
	input wire logic sda,
	output logic scl,
	output logic sdaPull
);
	logic suspendMode;
	logic dummy;

	initial begin
		scl = 1'b1;
		sdaPull = 1'b0;
		suspendMode = 1'b0;
	end

	task automatic half();
		repeat (HALF_CYC) @(posedge lclk);
	endtask

	// start or repeated start, clock toggles before any stop.
	task automatic start();
		sdaPull = 1'b0;
		half();
		scl = 1'b1;
		half();
		sdaPull = 1'b1;
		half();
		scl = 1'b0;
	endtask

	// Data moves well after the clock fall so it never looks like a start or stop.
	task automatic xfer_bit(input logic b, output logic r);
		repeat (4) @(posedge lclk);
		sdaPull = !b;
		half();
		scl = 1'b1;
		half();
		r = sda;
		scl = 1'b0;
	endtask

	task automatic send8(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(d[i], dummy);
		end
	endtask

	task automatic wr_byte(input logic [7:0] d, output logic ack);
		send8(d);
		xfer_bit(1'b1, ack);
	endtask

	// acknowledge zero to continue, one on the last byte.
	task automatic rd_byte(output logic [7:0] d, input logic nack);
		for (int i = 7; i >= 0; i--) begin
			xfer_bit(1'b1, d[i]);
		end
		xfer_bit(nack, dummy);
	endtask

	// stop, then idle long enough before the next access.
	task automatic stop();
		repeat (4) @(posedge lclk);
		sdaPull = 1'b1;
		half();
		scl = 1'b1;
		half();
		sdaPull = 1'b0;
		if (suspendMode) begin
			#(IDLE_SUSPEND_US * 1000);
		end else begin
			#(IDLE_NORMAL_NS);
		end
	endtask
endmodule

// ---- tb/sensor_i2c_register_slave_tb.sv ----
// Self-checking bench of the I2C register target: reads, writes, addressing, watchdog.
// Assumes the register file answers with its address plus 0x40.
`timescale 1ns/100ps
module sensor_i2c_register_slave_tb import sirs_pkg::*; ();
	logic clk, lclk, arst_n, scl, sdaPull, sda, addrSel, wdtEn, wdtLong;
	logic rdReq, rdValid, rdReady, wrStrobe, busy, wdtTrip, sdOut, sdOe;
	logic [7:0] rdAddr, rdData, wrAddr, wrData;
	logic [15:0] wq[$];
	int n_fail = 0;
	int num_checks = 0;
	int cycles = 0;

	assign sda = !(sdOe | sdaPull);

	sirs_i2c_target #(.WDT_SHORT_CYCLES(24'h40), .WDT_LONG_CYCLES(24'h100)) i_dut (
		.clk(clk), .arst_n(arst_n), .clkEn(1'b1), .serialClockPin(scl),
		.serialDataIn(sda), .serialDataOut(sdOut), .serialDataOe(sdOe),
		.addressSelectPin(addrSel), .wdtEnable(wdtEn), .wdtLongSel(wdtLong),
		.rdReq(rdReq), .rdAddr(rdAddr), .rdData(rdData), .rdValid(rdValid),
		.rdReady(rdReady), .wrStrobe(wrStrobe), .wrAddr(wrAddr), .wrData(wrData),
		.busy(busy), .wdtTrip(wdtTrip)
	);

	sirs_ctrl_model i2c (.lclk(lclk), .sda(sda), .scl(scl), .sdaPull(sdaPull));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = !clk;
	end

	initial begin
		lclk = 1'b0;
		#7;
		forever #16 lclk = !lclk;
	end

	// ****************************************
	// Register file model and write monitor
	// ****************************************
	always @(negedge clk) begin
		if (rdReq === 1'b1) begin
			repeat (3) @(negedge clk);
			rdData = rdAddr + 8'h40;
			rdValid = 1'b1;
			@(negedge clk);
			rdValid = 1'b0;
		end
	end

	always @(negedge clk) begin
		if (wrStrobe === 1'b1) begin
			wq.push_back({wrAddr, wrData});
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			n_fail++;
			report_and_stop();
		end
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic send(input logic [7:0] d, input logic expAck);
		logic ack;
		i2c.wr_byte(d, ack);
		check("target ack", {7'h00, ack}, {7'h00, expAck});
	endtask

	task automatic do_read(input logic [7:0] first, input int n);
		logic [7:0] d;
		send({TARGET_ADDR_LOW, DIR_READ}, 1'b0);
		for (int i = 0; i < n; i++) begin
			i2c.rd_byte(d, i == n - 1);
			check("read byte", d, first + 8'(i) + 8'h40);
		end
		repeat (10) @(negedge clk);
		check("released after nack", {7'h00, sdOe}, 8'h00);
		i2c.stop();
		check("idle after stop", {7'h00, busy}, 8'h00);
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		int n;
		arst_n = 1'b0;
		addrSel = 1'b0;
		wdtEn = 1'b0;
		wdtLong = 1'b0;
		rdData = 8'h00;
		rdValid = 1'b0;
		repeat (20) @(negedge clk);
		check("ready in reset", {7'h00, rdReady}, 8'h01);
		check("oe in reset", {7'h00, sdOe}, 8'h00);
		check("open drain out", {7'h00, sdOut}, 8'h00);
		arst_n = 1'b1;
		repeat (10) @(negedge clk);
		i2c.start();
		do_read(READ_START_RESET, 3);
		$display("test default start address done");
		i2c.start();
		send({TARGET_ADDR_LOW, 1'b0}, 1'b0);
		send(8'h12, 1'b0);
		send(8'ha5, 1'b0);
		send(8'h5a, 1'b0);
		i2c.stop();
		check("write count", 8'(wq.size()), 8'h02);
		check("write 0", wq[0][15:8] ^ wq[0][7:0], 8'h12 ^ 8'ha5);
		check("write 1", wq[1][15:8] ^ wq[1][7:0], 8'h13 ^ 8'h5a);
		check("write 0 addr", wq[0][15:8], 8'h12);
		check("write 0 data", wq[0][7:0], 8'ha5);
		check("write 1 addr", wq[1][15:8], 8'h13);
		check("write 1 data", wq[1][7:0], 8'h5a);
		$display("test write burst done");
		i2c.start();
		send({TARGET_ADDR_LOW, 1'b0}, 1'b0);
		send(8'h20, 1'b0);
		i2c.start();
		do_read(8'h20, 2);
		i2c.start();
		do_read(8'h20, 2);
		$display("test repeated read done");
		for (int p = 0; p < 2; p++) begin
			addrSel = p[0];
			repeat (10) @(negedge clk);
			i2c.start();
			send({TARGET_ADDR_HIGH, 1'b0}, !p[0]);
			send(8'h33, !p[0]);
			i2c.stop();
		end
		addrSel = 1'b0;
		check("no stray writes", 8'(wq.size()), 8'h02);
		$display("test address select done");
		for (int m = 0; m < 3; m++) begin
			wdtEn = (m != 2);
			wdtLong = (m == 1);
			i2c.start();
			i2c.send8({TARGET_ADDR_LOW, 1'b0});
			n = 0;
			while (sdOe !== 1'b1 && n < 50) begin
				@(negedge clk);
				n++;
			end
			n = 0;
			while (wdtTrip !== 1'b1 && n < 400) begin
				@(negedge clk);
				n++;
			end
			if (m == 0) begin
				check("short period", 8'(n >= 60 && n <= 72), 8'h01);
			end else if (m == 1) begin
				check("long period", 8'(n >= 252 && n <= 264), 8'h01);
			end else begin
				check("disabled", 8'(n), 8'(400));
			end
			if (m != 2) begin
				@(negedge clk);
				check("oe after trip", {7'h00, sdOe}, 8'h00);
				check("busy after trip", {7'h00, busy}, 8'h00);
			end else begin
				i2c.xfer_bit(1'b1, i2c.dummy);
			end
			i2c.stop();
		end
		i2c.start();
		do_read(8'h33, 1);
		$display("test watchdog done");
		arst_n = 1'b0;
		repeat (3) @(negedge clk);
		check("oe in second reset", {7'h00, sdOe}, 8'h00);
		arst_n = 1'b1;
		repeat (10) @(negedge clk);
		i2c.start();
		do_read(READ_START_RESET, 1);
		$display("test second reset done");
		report_and_stop();
	end
endmodule
